// ### shared/bkr_pkg.sv
// constants, register map and state types for the buck regulator control bank
package bkr_pkg;
    // register addresses on the two-wire control port
    localparam logic [7:0] ADDR_B1A_CONF = 8'h24;
    localparam logic [7:0] ADDR_B1B_VOLT = 8'h2E;
    localparam logic [7:0] ADDR_B1B_STBY = 8'h2F;
    localparam logic [7:0] ADDR_B1B_OFF = 8'h30;
    localparam logic [7:0] ADDR_B1B_MODE = 8'h31;
    localparam logic [7:0] ADDR_B1B_CONF = 8'h32;
    localparam logic [7:0] ADDR_B2_VOLT = 8'h35;
    localparam logic [7:0] ADDR_B2_STBY = 8'h36;
    // implemented bits per register kind
    localparam logic [7:0] MASK_CONF = 8'h7D;
    localparam logic [7:0] MASK_CONF_OTP = 8'h4D;
    localparam logic [7:0] MASK_VOLT = 8'h1F;
    localparam logic [7:0] MASK_B2_VOLT = 8'h3F;
    localparam logic [7:0] MASK_MODE = 8'h2F;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // field positions
    localparam int CONF_RAMP_BIT = 6;
    localparam int CONF_PHASE_LSB = 4;
    localparam int CONF_FREQ_LSB = 2;
    localparam int CONF_ILIM_BIT = 0;
    localparam int MODE_AFTER_OFF_BIT = 5;
    localparam int B2_RANGE_BIT = 5;
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int DVS_FAST_NS = 2000;
    localparam int DVS_SLOW_NS = 4000;
    localparam int DVS_FAST_CYCLES = (DVS_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DVS_SLOW_CYCLES = (DVS_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOW_CLK_HZ = 32768;
    localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_CLK_HZ;
    // two-wire slave states
    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_ACK_ADDR = 3'b010,
        I2C_RX = 3'b011,
        I2C_ACK_RX = 3'b100,
        I2C_TX = 3'b101,
        I2C_HOST_ACK = 3'b110
    } bkr_i2c_state_t;
    // power state of the regulators
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_STBY_WAIT = 2'b01,
        PWR_STANDBY = 2'b10,
        PWR_TURNED_OFF = 2'b11
    } bkr_pwr_state_t;
endpackage

// ### core/bkr_dvs_ramp.sv
// output voltage code stepper that walks toward a target one code per ramp interval
`timescale 1ns/1ps
module bkr_dvs_ramp #(
    parameter int CODE_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic init,
    input wire logic slow,
    input wire logic [CODE_W-1:0] target,
    output logic [CODE_W-1:0] code
);
    import bkr_pkg::*;

    localparam logic [7:0] FAST_LAST = 8'(DVS_FAST_CYCLES - 1);
    localparam logic [7:0] SLOW_LAST = 8'(DVS_SLOW_CYCLES - 1);

    logic [7:0] interval_cnt;

    // interval counter restarts whenever the code sits on target
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interval_cnt <= 8'h00;
        end else if (init || code == target) begin
            interval_cnt <= 8'h00;
        end else if (interval_cnt >= (slow ? SLOW_LAST : FAST_LAST)) begin
            interval_cnt <= 8'h00;
        end else begin
            interval_cnt <= interval_cnt + 8'h01;
        end
    end

    // one code step is one 25 mV step; rate taken from the ramp bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            code <= '0;
        end else if (init) begin
            code <= target; // start-up lands on the default, no ramp
        end else if (code != target && interval_cnt >= (slow ? SLOW_LAST : FAST_LAST)) begin
            code <= (code < target) ? code + 1'b1 : code - 1'b1;
        end
    end
endmodule

// ### core/bkr_regs.sv
// buck regulator control register bank with two-wire slave and standby control
// Behaviour
// - configuration bit 6 picks a 25 mV step each 2.0 or 4.0 us
// - configuration bits 5:4 hold the phase clock selection
// - configuration bits 3:2 hold the switching frequency code
// - configuration bit 0 selects current limit 2.75 A or 2.0 A
// - buck one B configuration at address 0x32, bits 7 and 1 read zero
// - configuration registers readable and writable at any time
// - ramp, frequency, limit load from OTP at reset; phase, reserved zero
// - buck one B and two normal voltage code in bits 4:0
// - buck one B and two standby voltage code in bits 4:0
// - buck one B sleep voltage code in bits 4:0
// - buck one B mode bit 5 picks off or sleep after turn-off
// - buck one B mode bits 3:0 hold the switching mode selector
// - buck two voltage bit 5 picks low or high range
// - buck two standby code independent of its normal code
// - standby entered after standby request plus 0..3 slow clock periods
`timescale 1ns/1ps
module bkr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h08, // arbitrary bus address
    parameter int TICK_CYCLES = bkr_pkg::SLOW_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic standby_req,
    input wire logic [1:0] standby_delay,
    input wire logic turnoff_req,
    input wire logic [7:0] otp_b1a_conf,
    input wire logic [7:0] otp_b1b_conf,
    input wire logic [7:0] otp_b1b_volt,
    input wire logic [7:0] otp_b1b_stby,
    input wire logic [7:0] otp_b1b_off,
    input wire logic [7:0] otp_b1b_mode,
    input wire logic [7:0] otp_b2_volt,
    input wire logic [7:0] otp_b2_stby,
    output logic buck_one_a_ramp_rate,
    output logic [1:0] buck_one_a_phase_sel,
    output logic [1:0] buck_one_a_freq_sel,
    output logic buck_one_a_current_limit,
    output logic buck_one_b_ramp_rate,
    output logic [1:0] buck_one_b_phase_sel,
    output logic [1:0] buck_one_b_freq_sel,
    output logic buck_one_b_current_limit,
    output logic [3:0] buck_one_b_switch_mode,
    output logic buck_one_b_enable,
    output logic [4:0] buck_one_b_vout,
    output logic buck_two_enable,
    output logic buck_two_high_range,
    output logic [4:0] buck_two_vout,
    output logic in_standby
);
    import bkr_pkg::*;

    localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);

    // register storage
    logic [7:0] b1a_conf, b1b_conf, b1b_volt, b1b_stby, b1b_off, b1b_mode, b2_volt, b2_stby;
    logic otp_load;
    logic ramp_init;

    // two-wire slave state
    bkr_i2c_state_t i2c_state;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] reg_ptr;
    logic [7:0] tx_byte;
    logic ptr_phase;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    // power state
    bkr_pwr_state_t pwr_state;
    logic [9:0] tick_cnt;
    logic [1:0] delay_cnt;
    logic [4:0] b1b_target;
    logic [4:0] b2_target;

    wire logic scl_rise = scl && !scl_q;
    wire logic scl_fall = !scl && scl_q;
    wire logic bus_start = scl && scl_q && sda_q && !sda_in;
    wire logic bus_stop = scl && scl_q && !sda_q && sda_in;

    // read view; unmapped reads zero, reserved bits masked
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        unique case (addr)
            ADDR_B1A_CONF: read_reg = b1a_conf & MASK_CONF;
            ADDR_B1B_CONF: read_reg = b1b_conf & MASK_CONF;
            ADDR_B1B_VOLT: read_reg = b1b_volt & MASK_VOLT;
            ADDR_B1B_STBY: read_reg = b1b_stby & MASK_VOLT;
            ADDR_B1B_OFF: read_reg = b1b_off & MASK_VOLT;
            ADDR_B1B_MODE: read_reg = b1b_mode & MASK_MODE;
            ADDR_B2_VOLT: read_reg = b2_volt & MASK_B2_VOLT;
            ADDR_B2_STBY: read_reg = b2_stby & MASK_B2_VOLT;
            default: read_reg = RESET_VALUE;
        endcase
    endfunction

    // line sampling for edge and start/stop detection; open-drain data only pulls low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            sda_out <= 1'b0;
        end
    end

    // slave protocol: address, pointer byte, then data with auto-increment
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_state <= I2C_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            reg_ptr <= 8'h00;
            tx_byte <= 8'h00;
            ptr_phase <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (bus_start) begin
                i2c_state <= I2C_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (bus_stop) begin
                i2c_state <= I2C_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (i2c_state)
                    I2C_IDLE: sda_oe <= 1'b0;
                    I2C_ADDR, I2C_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (i2c_state == I2C_ADDR) begin
                                if (shift[7:1] == DEV_ADDR) begin
                                    sda_oe <= 1'b1;
                                    i2c_state <= I2C_ACK_ADDR;
                                    ptr_phase <= !shift[0];
                                end else begin
                                    i2c_state <= I2C_IDLE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                i2c_state <= I2C_ACK_RX;
                                if (ptr_phase) begin
                                    reg_ptr <= shift;
                                    ptr_phase <= 1'b0;
                                end else begin
                                    // no mode gates a write
                                    wr_stb <= 1'b1;
                                    wr_addr <= reg_ptr;
                                    wr_data <= shift;
                                    reg_ptr <= reg_ptr + 8'h01;
                                end
                            end
                        end
                    end
                    I2C_ACK_ADDR: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (ptr_phase) begin
                                sda_oe <= 1'b0;
                                i2c_state <= I2C_RX;
                            end else begin
                                // read at any time
                                tx_byte <= read_reg(reg_ptr);
                                sda_oe <= (read_reg(reg_ptr) < 8'h80); // msb low pulls
                                reg_ptr <= reg_ptr + 8'h01;
                                i2c_state <= I2C_TX;
                            end
                        end
                    end
                    I2C_ACK_RX: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                            i2c_state <= I2C_RX;
                        end
                    end
                    I2C_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_oe <= 1'b0; // release for host acknowledge
                                i2c_state <= I2C_HOST_ACK;
                            end else begin
                                sda_oe <= !tx_byte[3'(4'h7 - bit_cnt)];
                            end
                        end
                    end
                    I2C_HOST_ACK: begin
                        if (scl_rise) begin
                            ptr_phase <= sda_in; // reuse: high means host refused
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (ptr_phase) begin
                                i2c_state <= I2C_IDLE;
                            end else begin
                                tx_byte <= read_reg(reg_ptr);
                                sda_oe <= (read_reg(reg_ptr) < 8'h80);
                                reg_ptr <= reg_ptr + 8'h01;
                                i2c_state <= I2C_TX;
                            end
                        end
                    end
                    default: i2c_state <= I2C_IDLE;
                endcase
            end
        end
    end

    // one-shot default load after reset release; phase and reserved stay zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_load <= 1'b1;
            ramp_init <= 1'b0;
        end else begin
            otp_load <= 1'b0;
            ramp_init <= otp_load;
        end
    end

    // register writes; defaults come from OTP, not constants
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            b1a_conf <= RESET_VALUE;
            b1b_conf <= RESET_VALUE;
            b1b_volt <= RESET_VALUE;
            b1b_stby <= RESET_VALUE;
            b1b_off <= RESET_VALUE;
            b1b_mode <= RESET_VALUE;
            b2_volt <= RESET_VALUE;
            b2_stby <= RESET_VALUE;
        end else if (otp_load) begin
            b1a_conf <= otp_b1a_conf & MASK_CONF_OTP;
            b1b_conf <= otp_b1b_conf & MASK_CONF_OTP;
            b1b_volt <= otp_b1b_volt & MASK_VOLT;
            b1b_stby <= otp_b1b_stby & MASK_VOLT;
            b1b_off <= otp_b1b_off & MASK_VOLT;
            b1b_mode <= otp_b1b_mode & MASK_MODE;
            b2_volt <= otp_b2_volt & MASK_B2_VOLT;
            b2_stby <= otp_b2_stby & MASK_B2_VOLT;
        end else if (wr_stb) begin
            unique case (wr_addr)
                ADDR_B1A_CONF: b1a_conf <= wr_data & MASK_CONF;
                ADDR_B1B_CONF: b1b_conf <= wr_data & MASK_CONF;
                ADDR_B1B_VOLT: b1b_volt <= wr_data & MASK_VOLT;
                ADDR_B1B_STBY: b1b_stby <= wr_data & MASK_VOLT;
                ADDR_B1B_OFF: b1b_off <= wr_data & MASK_VOLT;
                ADDR_B1B_MODE: b1b_mode <= wr_data & MASK_MODE;
                ADDR_B2_VOLT: b2_volt <= wr_data & MASK_B2_VOLT;
                ADDR_B2_STBY: b2_stby <= wr_data & MASK_B2_VOLT;
                default: ;
            endcase
        end
    end

    // configuration fields straight out of the register flops
    assign buck_one_a_ramp_rate = b1a_conf[CONF_RAMP_BIT];
    assign buck_one_a_phase_sel = b1a_conf[CONF_PHASE_LSB +: 2];
    assign buck_one_a_freq_sel = b1a_conf[CONF_FREQ_LSB +: 2];
    assign buck_one_a_current_limit = b1a_conf[CONF_ILIM_BIT];
    assign buck_one_b_ramp_rate = b1b_conf[CONF_RAMP_BIT];
    assign buck_one_b_phase_sel = b1b_conf[CONF_PHASE_LSB +: 2];
    assign buck_one_b_freq_sel = b1b_conf[CONF_FREQ_LSB +: 2];
    assign buck_one_b_current_limit = b1b_conf[CONF_ILIM_BIT];
    assign buck_one_b_switch_mode = b1b_mode[3:0];

    // slow clock tick derived from the system clock, 32 kHz nominal
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 10'h000;
        end else if (tick_cnt >= TICK_LAST) begin
            tick_cnt <= 10'h000;
        end else begin
            tick_cnt <= tick_cnt + 10'h001;
        end
    end

    // standby entry with programmed delay; turn-off has priority over standby
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_state <= PWR_NORMAL;
            delay_cnt <= 2'b00;
        end else if (turnoff_req) begin
            pwr_state <= PWR_TURNED_OFF;
        end else begin
            unique case (pwr_state)
                PWR_NORMAL: begin
                    if (standby_req) begin
                        delay_cnt <= standby_delay;
                        // zero delay goes straight to standby
                        pwr_state <= (standby_delay == 2'b00) ? PWR_STANDBY : PWR_STBY_WAIT;
                    end
                end
                PWR_STBY_WAIT: begin
                    if (!standby_req) begin
                        pwr_state <= PWR_NORMAL;
                    end else if (tick_cnt == TICK_LAST) begin
                        delay_cnt <= delay_cnt - 2'b01;
                        if (delay_cnt == 2'b01) begin
                            pwr_state <= PWR_STANDBY;
                        end
                    end
                end
                PWR_STANDBY: if (!standby_req) pwr_state <= PWR_NORMAL;
                PWR_TURNED_OFF: pwr_state <= PWR_NORMAL; // turn-off released
            endcase
        end
    end

    // pick the voltage register each regulator follows in each power state
    always_comb begin
        unique case (pwr_state)
            PWR_STANDBY: begin
                b1b_target = b1b_stby[4:0];
                b2_target = b2_stby[4:0];
            end
            PWR_TURNED_OFF: begin
                b1b_target = b1b_off[4:0];
                b2_target = b2_volt[4:0];
            end
            default: begin
                b1b_target = b1b_volt[4:0];
                b2_target = b2_volt[4:0];
            end
        endcase
    end

    // enables and range bit, registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buck_one_b_enable <= 1'b0;
            buck_two_enable <= 1'b0;
            buck_two_high_range <= 1'b0;
            in_standby <= 1'b0;
        end else begin
            in_standby <= (pwr_state == PWR_STANDBY);
            buck_two_enable <= !otp_load && pwr_state != PWR_TURNED_OFF;
            // after turn-off: off when bit clear, sleep when set
            buck_one_b_enable <= !otp_load && (pwr_state != PWR_TURNED_OFF
                || b1b_mode[MODE_AFTER_OFF_BIT]);
            buck_two_high_range <= (pwr_state == PWR_STANDBY) ? b2_stby[B2_RANGE_BIT]
                : b2_volt[B2_RANGE_BIT];
        end
    end

    // buck one B steps at its configured ramp rate
    bkr_dvs_ramp #(.CODE_W(5)) u_b1b_ramp (.sys_clk(sys_clk), .rst_n(rst_n), .init(ramp_init),
        .slow(b1b_conf[CONF_RAMP_BIT]), .target(b1b_target), .code(buck_one_b_vout));

    // buck two has no configuration register here, so it ramps at the fast rate
    bkr_dvs_ramp #(.CODE_W(5)) u_b2_ramp (.sys_clk(sys_clk), .rst_n(rst_n), .init(ramp_init),
        .slow(1'b0), .target(b2_target), .code(buck_two_vout));
endmodule

// ### bench/bkr_host.sv
// two-wire host model for the bank's control port
`timescale 1ns/1ps
module bkr_host #(
    parameter logic [6:0] DEV = 7'h08
) (
    input wire logic sys_clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_in
);
    logic pull_low = 1'b0;
    // open drain with pull-up: a released line reads high
    assign sda_in = ~(pull_low | sda_oe);
    initial scl = 1'b1;
    // one clock pulse; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        @(negedge sys_clk) pull_low = ~b;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (4) @(negedge sys_clk);
        r = sda_in;
        scl = 1'b0;
    endtask
    task automatic start_c;
        @(negedge sys_clk) pull_low = 1'b0;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (4) @(negedge sys_clk);
        pull_low = 1'b1;
        repeat (4) @(negedge sys_clk);
        scl = 1'b0;
    endtask
    task automatic stop_c;
        @(negedge sys_clk) pull_low = 1'b1;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (4) @(negedge sys_clk);
        pull_low = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    // eight bits msb first, ninth bit is the acknowledge slot
    task automatic byte_x(input logic [7:0] b, input logic a9, output logic [7:0] r,
            output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(a9, ack);
    endtask
    // accesses ignore power state
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
            output logic ack);
        logic [7:0] t;
        logic k;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, t, ack);
        byte_x(a, 1'b1, t, k);
        byte_x(d, 1'b1, t, k);
        stop_c();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] t;
        logic k;
        start_c();
        byte_x({DEV, 1'b0}, 1'b1, t, k);
        byte_x(a, 1'b1, t, k);
        start_c();
        byte_x({DEV, 1'b1}, 1'b1, t, k);
        byte_x(8'hFF, 1'b1, d, k);
        stop_c();
    endtask
endmodule

// ### bench/bkr_regs_chk.sv
// port-level checks for the buck regulator control bank
`timescale 1ns/1ps
module bkr_regs_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_oe,
    input wire logic standby_req,
    input wire logic [1:0] standby_delay,
    input wire logic turnoff_req,
    input wire logic [1:0] buck_one_a_phase_sel,
    input wire logic buck_one_b_ramp_rate,
    input wire logic [1:0] buck_one_b_phase_sel,
    input wire logic [1:0] buck_one_b_freq_sel,
    input wire logic [3:0] buck_one_b_switch_mode,
    input wire logic buck_one_b_enable,
    input wire logic [4:0] buck_one_b_vout,
    input wire logic buck_two_enable,
    input wire logic in_standby
);
    logic [1:0] cyc;
    logic [7:0] gap;
    logic armed;
    logic [4:0] vout_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // cycles since reset, saturating so the otp load edges stay excluded
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cyc <= 2'h0;
        else if (cyc != 2'h3) cyc <= cyc + 2'h1;
    end
    // gap since the last voltage step; first change is the jump to target
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 8'h00;
            armed <= 1'b0;
            vout_q <= 5'h00;
        end else begin
            vout_q <= buck_one_b_vout;
            armed <= armed | (buck_one_b_vout != vout_q);
            gap <= (buck_one_b_vout != vout_q) ? 8'h00 : gap + {7'h00, gap != 8'hFF};
        end
    end
    dvs_step_gap_a: assert property (
        buck_one_b_vout != vout_q && armed && buck_one_b_enable && $past(buck_one_b_enable)
        |-> gap >= (buck_one_b_ramp_rate ? 8'h63 : 8'h31)) else $error("step too early");
    phase_reset_a: assert property (
        cyc != 2'h3 |-> buck_one_a_phase_sel == 2'h0 && buck_one_b_phase_sel == 2'h0)
        else $error("phase not zero after reset");
    freq_by_bus_a: assert property (
        $changed(buck_one_b_freq_sel) && cyc == 2'h3 |-> !$past(scl)) else $error("freq moved");
    mode_by_bus_a: assert property (
        $changed(buck_one_b_switch_mode) && cyc == 2'h3 |-> !$past(scl)) else $error("mode moved");
    ack_drive_a: assert property (
        $changed(sda_oe) |-> !$past(scl)) else $error("data line moved with clock high");
    stby_enter_a: assert property (
        (standby_req && standby_delay == 2'h0 && !turnoff_req) [*3] |=> in_standby)
        else $error("standby not entered");
    stby_exit_a: assert property (
        $fell(standby_req) |-> ##[1:3] !in_standby) else $error("standby not left");
    turnoff_off_a: assert property (
        turnoff_req [*4] |-> !buck_two_enable) else $error("buck two still on");
endmodule
bind bkr_regs bkr_regs_chk u_chk (.sys_clk, .rst_n, .scl, .sda_oe, .standby_req,
    .standby_delay, .turnoff_req, .buck_one_a_phase_sel, .buck_one_b_ramp_rate,
    .buck_one_b_phase_sel, .buck_one_b_freq_sel, .buck_one_b_switch_mode,
    .buck_one_b_enable, .buck_one_b_vout, .buck_two_enable, .in_standby);

// ### bench/tb_buck_regulator_control_regs.sv
// self-checking bench for the buck regulator control bank
`timescale 1ns/1ps
module tb_buck_regulator_control_regs;
    import bkr_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, standby_req = 1'b0, turnoff_req = 1'b0;
    logic [1:0] standby_delay = 2'h0;
    logic [7:0] otp = 8'hFF, rd;
    logic scl, sda_in, sda_oe, ack, a_rr, a_il, b_rr, b_il, b_en, t_en, t_hi, stby;
    logic [1:0] a_ph, a_fr, b_ph, b_fr;
    logic [3:0] b_sw;
    logic [4:0] b_vo, t_vo;
    // address, value written, value read back
    logic [23:0] rows [9] = '{24'h32_FF7D, 24'h24_FF7D, 24'h2E_FF1F, 24'h2F_FF1F,
        24'h30_FF1F, 24'h31_FF2F, 24'h35_FF3F, 24'h36_FF3F, 24'h40_FF00};
    int failures = 0, n_compared = 0, cycles = 0;
    bkr_host #(.DEV(7'h08)) u_host (.sys_clk, .sda_oe, .scl, .sda_in);
    bkr_regs #(.DEV_ADDR(7'h08), .TICK_CYCLES(4)) u_dut (.sys_clk, .rst_n, .scl, .sda_in,
        .sda_out(), .sda_oe, .standby_req, .standby_delay, .turnoff_req, .otp_b1a_conf(otp),
        .otp_b1b_conf(otp), .otp_b1b_volt(otp), .otp_b1b_stby(otp), .otp_b1b_off(otp),
        .otp_b1b_mode(otp), .otp_b2_volt(otp), .otp_b2_stby(otp), .buck_one_a_ramp_rate(a_rr),
        .buck_one_a_phase_sel(a_ph), .buck_one_a_freq_sel(a_fr), .buck_one_a_current_limit(a_il),
        .buck_one_b_ramp_rate(b_rr), .buck_one_b_phase_sel(b_ph), .buck_one_b_freq_sel(b_fr),
        .buck_one_b_current_limit(b_il), .buck_one_b_switch_mode(b_sw), .buck_one_b_enable(b_en),
        .buck_one_b_vout(b_vo), .buck_two_enable(t_en), .buck_two_high_range(t_hi),
        .buck_two_vout(t_vo), .in_standby(stby));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial forever #20 sys_clk = ~sys_clk;
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            u_host.wr(7'h08, rows[i][23:16], rows[i][15:8], ack);
            u_host.rd(rows[i][23:16], rd);
            chk("readback", rd, rows[i][7:0]);
        end
        u_host.wr(7'h08, ADDR_B1A_CONF, 8'h3C, ack);
        u_host.wr(7'h08, ADDR_B1B_CONF, 8'h41, ack);
        chk("a_fields", {2'h0, a_rr, a_ph, a_fr, a_il}, 8'h1E);
        chk("b_fields", {2'h0, b_rr, b_ph, b_fr, b_il}, 8'h21);
        chk("switch_mode", {4'h0, b_sw}, 8'h0F);
        // foreign address: no ack, register kept
        u_host.wr(7'h09, ADDR_B1B_CONF, 8'h00, ack);
        chk("foreign_ack", {7'h00, ack}, 8'h01);
        u_host.rd(ADDR_B1B_CONF, rd);
        chk("b_conf_kept", rd, 8'h41);
        u_host.wr(7'h08, ADDR_B2_VOLT, 8'h3E, ack);
        u_host.wr(7'h08, ADDR_B2_STBY, 8'h1C, ack);
        u_host.wr(7'h08, ADDR_B1B_STBY, 8'h1D, ack);
        standby_req = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("standby", {7'h00, stby}, 8'h01);
        chk("b2_range_stby", {7'h00, t_hi}, 8'h00);
        repeat (300) @(negedge sys_clk);
        chk("b2_vout_stby", {3'h0, t_vo}, 8'h1C);
        chk("b1b_vout_stby", {3'h0, b_vo}, 8'h1D);
        standby_req = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("b2_range_norm", {7'h00, t_hi}, 8'h01);
        standby_delay = 2'h3;
        standby_req = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk("standby_late", {7'h00, stby}, 8'h01);
        standby_req = 1'b0;
        // off versus sleep after turn-off
        for (int m = 0; m < 2; m++) begin
            u_host.wr(7'h08, ADDR_B1B_MODE, m[0] ? 8'h25 : 8'h05, ack);
            turnoff_req = 1'b1;
            repeat (6) @(negedge sys_clk);
            chk("b1b_en_off", {7'h00, b_en}, {7'h00, m[0]});
            chk("b2_en_off", {7'h00, t_en}, 8'h00);
            turnoff_req = 1'b0;
            repeat (6) @(negedge sys_clk);
        end
        rst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        u_host.rd(ADDR_B1B_CONF, rd);
        chk("b_conf_reset", rd, 8'h4D);
        end_sim();
    end
endmodule
